/* core/bl_seq_map.svh */
// Constant map: timing, register offsets and field positions of the backlight sequencer
`ifndef BL_SEQ_MAP_SVH
`define BL_SEQ_MAP_SVH
`define CLK_PERIOD_NS 5
`define CLK_FREQ_HZ 200000000
`define OSC_FREQ_HZ 2000000
`define OSC_DIV (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define OSC_DIV_W 7
`define SHDN_OSC_CYCLES 131072
`define SHDN_CNT_W 18
`define SUPPLY_FILTER_NS 50000
`define SUPPLY_FILTER_CYCLES ((`SUPPLY_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W 18
`define APB_AW 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FAULT 12'h008
`define CTRL_RESET 32'h0000_0001
`define CTRL_RUN 0
`define ST_STATE_LSB 0
`define ST_MASK_LSB 4
`define ST_LOCK_LSB 8
`define ST_REGUL_LSB 12
`define ST_UV_OK 16
`define ST_OV_DIS 17
`define ST_OVP 18
`define ST_THERM 19
`define FLT_SHORT 0
`define FLT_OPEN_DIODE 1
`define FLT_OVERCUR 2
`define NUM_SYNC 22
`endif

/* core/bl_seq_pkg.sv */
// Types shared by the backlight sequencer
package bl_seq_pkg;
  typedef enum logic [3:0] {
    ST_SHDN = 4'b0001,
    ST_SOFT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_IDLE = 4'b1000
  } seq_state_e;
  typedef logic [3:0] chan_t;
endpackage : bl_seq_pkg

/* core/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : pin_sync

/* core/run_timer.sv */
// Saturating run-length timer: counts ticks while i_run holds, restarts from zero when it drops
`timescale 1ns/1ps
module run_timer #(
  parameter int W = 18,
  parameter logic [W-1:0] LIMIT = '1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire logic i_tick,
  // Status
  output logic o_expired
);
  logic [W-1:0] count_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
      count_reg <= '0;
    end else if (i_tick && count_reg != LIMIT) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign o_expired = (count_reg == LIMIT);

  restart_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R24
    !i_run |=> (count_reg == '0) && !o_expired)
    else $error("timer did not restart when run dropped");
endmodule : run_timer

/* core/backlight_sequencer.sv */
// Control and fault sequencer of a four-channel LED backlight driver with APB registers
`timescale 1ns/1ps
`include "bl_seq_map.svh"

// Overview of operation
// (R1) Select pins decode one to four channels
// (R2) Short check covers non-enabled channels too
// (R3) Soft-start: limited boost, sinks at one twentieth
// (R4) Leave soft-start when enabled channels regulate
// (R5) Enable high: boost and enabled sinks on
// (R6) Enable low: all off, compensation floats
// (R7) Long enable low: shutdown, clear fault latches
// (R8) Timeout is 131072 oscillator cycles exceeded
// (R9) After shutdown, enable restarts through soft-start
// (R10) Host drives enable PWM at 100-300 Hz
// (R11) Dim input high selects quarter current
// (R12) Overvoltage locks out unregulated channels
// (R13) Every overvoltage event re-evaluates all channels
// (R14) Lock-out survives enable low until shutdown
// (R15) Locked-out sinks still draw desired current
// (R16) Channel short latches boost and sinks off
// (R17) Overvoltage comparator: set 200, release 165
// (R18) Switch node overvoltage latches device off
// (R19) Switch current limit ends each pulse
// (R20) Output overcurrent latches disconnect switch off
// (R21) Undervoltage: hysteretic on, 50 us filtered off
// (R22) Input overvoltage over 50 us disables boost
// (R23) Thermal follow: below 1.1, until 1.23
// (R24) Enable rising edge restarts shutdown count
// (R25) Latched faults hold until shutdown timeout
module backlight_sequencer #(
  parameter int SHDN_TICKS = `SHDN_OSC_CYCLES,
  parameter int FILTER_CYCLES = `SUPPLY_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Host pins
  input wire logic i_enable_pwm,
  input wire logic i_channel_select_lo,
  input wire logic i_channel_select_hi,
  input wire logic i_quarter_current_input,
  // Analog comparator levels
  input wire logic [3:0] i_sink_regulated,
  input wire logic [3:0] i_sink_short,
  input wire logic i_ovp_above_set,
  input wire logic i_ovp_below_release,
  input wire logic i_switch_node_overvolt,
  input wire logic i_switch_current_limit,
  input wire logic i_disconnect_overcurrent,
  input wire logic i_vin_above_uvlo_hys,
  input wire logic i_vin_below_uvlo,
  input wire logic i_vin_above_ovlo,
  input wire logic i_thermal_below_low,
  input wire logic i_thermal_below_high,
  // Power stage controls
  output logic o_boost_en,
  output logic o_boost_soft_limit,
  output logic o_pulse_terminate,
  output logic o_disconnect_en,
  output logic o_comp_float,
  output logic o_comp_hold_low,
  output logic [3:0] o_sink_en,
  output logic o_sink_soft_level,
  output logic o_sink_quarter,
  output logic [3:0] o_loop_lockout,
  output logic o_thermal_follow,
  output logic o_shutdown
);
  localparam logic [`SHDN_CNT_W-1:0] SHDN_LIMIT = `SHDN_CNT_W'(SHDN_TICKS + 1);
  localparam logic [`FILT_CNT_W-1:0] FILT_LIMIT = `FILT_CNT_W'(FILTER_CYCLES + 1);
  localparam logic [`OSC_DIV_W-1:0] OSC_LAST = `OSC_DIV_W'(`OSC_DIV - 1);

  function automatic bl_seq_pkg::chan_t decode_sel(input logic lo, input logic hi);
    case ({hi, lo})
      2'b00: decode_sel = 4'h1;
      2'b01: decode_sel = 4'h3;
      2'b10: decode_sel = 4'h7;
      default: decode_sel = 4'hF;
    endcase
  endfunction : decode_sel

  // Synchronised pin levels
  logic [`NUM_SYNC-1:0] sync_w;
  logic en_s, sel_lo_s, sel_hi_s, dim_s, ovp_set_s, ovp_rel_s, node_ov_s, ilim_s;
  logic oc_s, uv_hys_s, uv_low_s, ov_hi_s, th_lo_s, th_hi_s;
  bl_seq_pkg::chan_t regul_s, short_s;

  pin_sync #(.W(`NUM_SYNC)) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_enable_pwm, i_channel_select_lo, i_channel_select_hi,
      i_quarter_current_input, i_ovp_above_set, i_ovp_below_release,
      i_switch_node_overvolt, i_switch_current_limit, i_disconnect_overcurrent,
      i_vin_above_uvlo_hys, i_vin_below_uvlo, i_vin_above_ovlo,
      i_thermal_below_low, i_thermal_below_high, i_sink_regulated, i_sink_short}),
    .o_sync(sync_w)
  );

  assign {en_s, sel_lo_s, sel_hi_s, dim_s, ovp_set_s, ovp_rel_s, node_ov_s, ilim_s,
    oc_s, uv_hys_s, uv_low_s, ov_hi_s, th_lo_s, th_hi_s, regul_s, short_s} = sync_w;

  // State
  bl_seq_pkg::seq_state_e state_reg, state_next;
  logic [`OSC_DIV_W-1:0] osc_cnt_reg;
  logic [31:0] ctrl_reg;
  logic uv_ok_reg, ov_dis_reg, ovp_reg, therm_reg, soft_done_reg;
  logic flt_short_reg, flt_diode_reg, flt_oc_reg;
  bl_seq_pkg::chan_t lockout_reg, lockout_next;
  logic [31:0] prdata_reg;

  // Decoded conditions
  wire osc_tick = (osc_cnt_reg == OSC_LAST);
  wire bl_seq_pkg::chan_t ch_mask = decode_sel(sel_lo_s, sel_hi_s); // R1
  wire all_regulated = ((regul_s & ch_mask) == ch_mask);
  wire supply_ok = uv_ok_reg && !ov_dis_reg;
  wire fault_any = flt_short_reg || flt_diode_reg || flt_oc_reg;
  wire in_soft = (state_reg == bl_seq_pkg::ST_SOFT);
  wire in_run = (state_reg == bl_seq_pkg::ST_RUN);
  wire in_idle = (state_reg == bl_seq_pkg::ST_IDLE);
  wire run_bit = ctrl_reg[`CTRL_RUN];
  wire active = en_s && supply_ok && !fault_any && run_bit && (in_soft || in_run); // R5
  wire ovp_next = ovp_set_s || (ovp_reg && !ovp_rel_s); // R17
  wire ovp_rise = ovp_next && !ovp_reg;
  wire sd_expired, uv_expired, ov_expired;
  wire sd_clear = sd_expired && in_idle; // R7

  // Shutdown timeout counts oscillator ticks of one continuous low period
  run_timer #(.W(`SHDN_CNT_W), .LIMIT(SHDN_LIMIT)) u_shdn_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(!en_s && in_idle), // R24
    .i_tick(osc_tick), // R8
    .o_expired(sd_expired)
  );

  // Supply glitch filters run on the system clock
  run_timer #(.W(`FILT_CNT_W), .LIMIT(FILT_LIMIT)) u_uv_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(uv_low_s),
    .i_tick(1'b1),
    .o_expired(uv_expired)
  );

  run_timer #(.W(`FILT_CNT_W), .LIMIT(FILT_LIMIT)) u_ov_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(ov_hi_s),
    .i_tick(1'b1),
    .o_expired(ov_expired)
  );

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bl_seq_pkg::ST_SHDN: begin
        if (en_s && supply_ok) begin
          state_next = bl_seq_pkg::ST_SOFT; // R9
        end
      end
      bl_seq_pkg::ST_SOFT: begin
        if (!en_s) begin
          state_next = bl_seq_pkg::ST_IDLE;
        end else if (all_regulated && supply_ok && !fault_any) begin
          state_next = bl_seq_pkg::ST_RUN; // R4
        end
      end
      bl_seq_pkg::ST_RUN: begin
        if (!en_s) begin
          state_next = bl_seq_pkg::ST_IDLE;
        end else if (!supply_ok) begin
          state_next = bl_seq_pkg::ST_SOFT;
        end
      end
      bl_seq_pkg::ST_IDLE: begin
        if (sd_clear) begin
          state_next = bl_seq_pkg::ST_SHDN;
        end else if (en_s) begin
          state_next = soft_done_reg ? bl_seq_pkg::ST_RUN : bl_seq_pkg::ST_SOFT;
        end
      end
      default: state_next = bl_seq_pkg::ST_SHDN;
    endcase
  end

  // Each overvoltage edge retests every enabled channel; a set beats the shutdown clear
  assign lockout_next = ovp_rise ? (ch_mask & ~regul_s) : // R12 R13
    (sd_clear ? 4'h0 : lockout_reg); // R14

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= bl_seq_pkg::ST_SHDN;
      osc_cnt_reg <= '0;
      soft_done_reg <= 1'b0;
      lockout_reg <= 4'h0;
      ovp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      osc_cnt_reg <= osc_tick ? '0 : osc_cnt_reg + 1'b1;
      soft_done_reg <= (in_soft && state_next == bl_seq_pkg::ST_RUN) ||
        (soft_done_reg && !sd_clear && supply_ok);
      lockout_reg <= lockout_next;
      ovp_reg <= ovp_next;
    end
  end

  // Latched faults: new events win over the shutdown clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flt_short_reg <= 1'b0;
      flt_diode_reg <= 1'b0;
      flt_oc_reg <= 1'b0;
    end else begin
      flt_short_reg <= (|short_s) || (flt_short_reg && !sd_clear); // R2 R16 R25
      flt_diode_reg <= node_ov_s || (flt_diode_reg && !sd_clear); // R18 R25
      flt_oc_reg <= oc_s || (flt_oc_reg && !sd_clear); // R20 R25
    end
  end

  // Supply monitors and thermal hysteresis
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      uv_ok_reg <= 1'b0;
      ov_dis_reg <= 1'b0;
      therm_reg <= 1'b0;
    end else begin
      uv_ok_reg <= uv_hys_s || (uv_ok_reg && !uv_expired); // R21
      ov_dis_reg <= ov_expired || (ov_dis_reg && !(!ov_hi_s && en_s)); // R22
      therm_reg <= th_lo_s || (therm_reg && th_hi_s); // R23
    end
  end

  // Registered power stage controls
  logic boost_reg, boost_lim_reg, term_reg, disc_reg, cfloat_reg, chold_reg;
  logic soft_lvl_reg, quarter_reg, therm_out_reg, shdn_reg;
  bl_seq_pkg::chan_t sink_reg, lock_out_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      boost_reg <= 1'b0;
      boost_lim_reg <= 1'b0;
      term_reg <= 1'b0;
      disc_reg <= 1'b0;
      cfloat_reg <= 1'b1;
      chold_reg <= 1'b0;
      sink_reg <= 4'h0;
      soft_lvl_reg <= 1'b0;
      quarter_reg <= 1'b0;
      lock_out_reg <= 4'h0;
      therm_out_reg <= 1'b0;
      shdn_reg <= 1'b1;
    end else begin
      boost_reg <= active && !ov_expired; // R5 R6 R22
      boost_lim_reg <= active && in_soft; // R3
      term_reg <= ilim_s; // R19
      disc_reg <= !flt_oc_reg && !oc_s; // R20
      cfloat_reg <= !en_s; // R6
      chold_reg <= in_soft;
      sink_reg <= active ? ch_mask : 4'h0; // R15
      soft_lvl_reg <= active && in_soft; // R3
      quarter_reg <= dim_s; // R11
      lock_out_reg <= lockout_reg;
      therm_out_reg <= therm_reg;
      shdn_reg <= (state_reg == bl_seq_pkg::ST_SHDN);
    end
  end

  assign o_boost_en = boost_reg;
  assign o_boost_soft_limit = boost_lim_reg;
  assign o_pulse_terminate = term_reg;
  assign o_disconnect_en = disc_reg;
  assign o_comp_float = cfloat_reg;
  assign o_comp_hold_low = chold_reg;
  assign o_sink_en = sink_reg;
  assign o_sink_soft_level = soft_lvl_reg;
  assign o_sink_quarter = quarter_reg;
  assign o_loop_lockout = lock_out_reg;
  assign o_thermal_follow = therm_out_reg;
  assign o_shutdown = shdn_reg;

  // APB slave: zero wait states, read data captured in the setup phase
  wire hit_ctrl = (i_paddr == `REG_CTRL);
  wire hit_status = (i_paddr == `REG_STATUS);
  wire hit_fault = (i_paddr == `REG_FAULT);
  wire hit_any = hit_ctrl || hit_status || hit_fault;
  wire setup_ph = i_psel && !i_penable;
  wire access_ph = i_psel && i_penable;
  wire wr_ctrl = access_ph && i_pwrite && hit_ctrl;

  logic [31:0] status_w, fault_w, rdata_w;
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`ST_STATE_LSB +: 4] = state_reg;
    status_w[`ST_MASK_LSB +: 4] = ch_mask;
    status_w[`ST_LOCK_LSB +: 4] = lockout_reg;
    status_w[`ST_REGUL_LSB +: 4] = regul_s;
    status_w[`ST_UV_OK] = uv_ok_reg;
    status_w[`ST_OV_DIS] = ov_dis_reg;
    status_w[`ST_OVP] = ovp_reg;
    status_w[`ST_THERM] = therm_reg;
    fault_w = 32'h0000_0000;
    fault_w[`FLT_SHORT] = flt_short_reg;
    fault_w[`FLT_OPEN_DIODE] = flt_diode_reg;
    fault_w[`FLT_OVERCUR] = flt_oc_reg;
  end

  assign rdata_w = hit_ctrl ? ctrl_reg : (hit_status ? status_w :
    (hit_fault ? fault_w : 32'h0000_0000));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {31'h0000_0000, i_pwdata[`CTRL_RUN]};
      end
      if (setup_ph && !i_pwrite) begin
        prdata_reg <= rdata_w;
      end
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = access_ph && !hit_any;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence short_seen_s;
    |short_s;
  endsequence
  sequence held_off_s;
    flt_short_reg ##1 (!o_boost_en && o_sink_en == 4'h0);
  endsequence

  chan_decode_a: assert property ((o_sink_en & ~decode_sel($past(sel_lo_s), // R1
    $past(sel_hi_s))) == 4'h0)
    else $error("sink enabled outside selected channels");
  short_latch_a: assert property (short_seen_s |=> held_off_s) // R2
    else $error("short did not latch outputs off");
  soft_level_a: assert property (active && in_soft |=> o_sink_soft_level && // R3
    o_boost_soft_limit && o_comp_hold_low)
    else $error("soft-start levels missing");
  soft_exit_a: assert property (in_soft && en_s && all_regulated && supply_ok && // R4
    !fault_any |=> in_run ##1 !o_sink_soft_level)
    else $error("soft-start did not end");
  en_low_off_a: assert property (!en_s |=> !o_boost_en && o_sink_en == 4'h0 && // R6
    o_comp_float)
    else $error("enable low did not turn outputs off");
  shdn_clear_a: assert property (sd_clear && !ovp_rise && short_s == 4'h0 && !node_ov_s && // R7
    !oc_s |=> state_reg == bl_seq_pkg::ST_SHDN && !fault_any && lockout_reg == 4'h0)
    else $error("shutdown did not clear latches");
  restart_soft_a: assert property (state_reg == bl_seq_pkg::ST_SHDN && en_s && // R9
    supply_ok |=> in_soft)
    else $error("restart skipped soft-start");
  lock_eval_a: assert property (ovp_rise |=> lockout_reg == $past(ch_mask & ~regul_s)) // R12
    else $error("lock-out not re-evaluated");
  lock_hold_a: assert property (!ovp_rise && !sd_clear |=> $stable(lockout_reg)) // R14
    else $error("lock-out changed without cause");
  fault_hold_a: assert property (fault_any && !sd_clear |=> fault_any) // R25
    else $error("latched fault lost before shutdown");
  ovp_hyst_a: assert property (ovp_reg && !ovp_rel_s |=> ovp_reg) // R17
    else $error("overvoltage released above release level");
  uv_filter_a: assert property ($fell(uv_ok_reg) |-> $past(uv_expired)) // R21
    else $error("undervoltage disable without filter time");
  dim_a: assert property (dim_s |=> o_sink_quarter) // R11
    else $error("dim input not applied");
endmodule : backlight_sequencer

/* sim/host_pwm_model.sv */
// Host model: drives the enable pin, either static or as a dimming train, and the select straps
`timescale 1ns/1ps
module host_pwm_model #(
  parameter int HIGH_CYC = 41,
  parameter int LOW_CYC = 40
) (
  // Clock
  input wire logic i_clk,
  // Control from the bench
  input wire logic i_pwm_on,
  input wire logic i_level,
  input wire logic [1:0] i_sel,
  // Pins
  output logic o_enable,
  output logic o_sel_lo,
  output logic o_sel_hi
);
  int cnt = 0;
  initial o_enable = 1'b0;
  // Straps are fixed levels on the board
  assign o_sel_lo = i_sel[0];
  assign o_sel_hi = i_sel[1];
  // Scaled-down dimming train; the extra high cycle offsets the turn-on delay
  always @(posedge i_clk) begin
    if (!i_pwm_on) begin
      cnt <= 0;
      o_enable <= i_level;
    end else if (cnt == (o_enable ? HIGH_CYC : LOW_CYC) - 1) begin
      cnt <= 0;
      o_enable <= ~o_enable;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : host_pwm_model

/* sim/test_backlight_sequencer.sv */
// Self-checking bench for the backlight sequencer
`timescale 1ns/1ps
`include "bl_seq_map.svh"
module test_backlight_sequencer;
  localparam int SHDN = 8;
  localparam int FILT = 16;
  // Always past the shutdown count, whatever the tick phase
  localparam int LONG_LOW = (SHDN + 3) * `OSC_DIV;
  localparam int SHORT_LOW = (SHDN - 1) * `OSC_DIV;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [`APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, enable, sel_lo, sel_hi;
  logic pwm_on = 1'b0, level = 1'b0, quarter = 1'b0;
  logic [1:0] sel = 2'h0;
  bl_seq_pkg::chan_t regulated = '0, shorted = '0, sink_en, lockout;
  logic overvoltage_sense = 1'b0, ovp_rel = 1'b1, node_ov = 1'b0, ilim = 1'b0, oc = 1'b0;
  logic uv_ok = 1'b0, uv_low = 1'b1, ovlo = 1'b0, th_lo = 1'b0, th_hi = 1'b0;
  logic boost_en, soft_lim, term, disc_en, comp_float, hold_low, sink_soft, sink_qtr;
  logic th_follow, shdn;
  int mismatches = 0, n_tests = 0;

  host_pwm_model u_host (.i_clk(clk), .i_pwm_on(pwm_on), .i_level(level), .i_sel(sel),
    .o_enable(enable), .o_sel_lo(sel_lo), .o_sel_hi(sel_hi));
  backlight_sequencer #(.SHDN_TICKS(SHDN), .FILTER_CYCLES(FILT)) u_dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_enable_pwm(enable),
    .i_channel_select_lo(sel_lo), .i_channel_select_hi(sel_hi),
    .i_quarter_current_input(quarter), .i_sink_regulated(regulated), .i_sink_short(shorted),
    .i_ovp_above_set(overvoltage_sense), .i_ovp_below_release(ovp_rel), .i_switch_node_overvolt(node_ov),
    .i_switch_current_limit(ilim), .i_disconnect_overcurrent(oc),
    .i_vin_above_uvlo_hys(uv_ok), .i_vin_below_uvlo(uv_low), .i_vin_above_ovlo(ovlo),
    .i_thermal_below_low(th_lo), .i_thermal_below_high(th_hi), .o_boost_en(boost_en),
    .o_boost_soft_limit(soft_lim), .o_pulse_terminate(term), .o_disconnect_en(disc_en),
    .o_comp_float(comp_float), .o_comp_hold_low(hold_low), .o_sink_en(sink_en),
    .o_sink_soft_level(sink_soft), .o_sink_quarter(sink_qtr), .o_loop_lockout(lockout),
    .o_thermal_follow(th_follow), .o_shutdown(shdn));

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic bl_seq_pkg::chan_t chan_mask(input logic [1:0] s);
    return s[1] ? (s[0] ? 4'hF : 4'h7) : (s[0] ? 4'h3 : 4'h1);
  endfunction : chan_mask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle limit here: the watchdog ends a wait that never finishes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps a following call from raising psel in this same time step
    @(posedge clk);
  endtask : apb

  task automatic ovp_pulse(input bl_seq_pkg::chan_t r);
    regulated <= r;
    overvoltage_sense <= 1'b1;
    ovp_rel <= 1'b0;
    cyc(8);
    overvoltage_sense <= 1'b0;
    ovp_rel <= 1'b1;
    cyc(8);
  endtask : ovp_pulse

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    cyc(40000);
    mismatches++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic e;
    bl_seq_pkg::chan_t m;
    void'($urandom(4899));
    cyc(20);
    sys_rst <= 1'b0;
    cyc(1);
    apb(1'b0, `REG_CTRL, 32'h0, q, e);
    chk("ctrl", q, `CTRL_RESET);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", q, 32'h0000_0000);
    uv_ok <= 1'b1;
    uv_low <= 1'b0;
    // Each pass ends in shutdown, so the next pass starts through soft-start
    for (int s = 0; s < 4; s++) begin
      m = chan_mask(s[1:0]);
      sel <= s[1:0];
      regulated <= 4'h0;
      level <= 1'b1;
      cyc(8);
      chk("sink_en", sink_en, m);
      chk("soft", {boost_en, soft_lim, sink_soft, hold_low}, 4'hF);
      regulated <= m;
      cyc(8);
      chk("run", {boost_en, soft_lim, sink_soft, hold_low, sink_en}, {4'h8, m});
      q = $urandom;
      quarter <= q[0];
      cyc(8);
      chk("quarter", sink_qtr, q[0]);
      level <= 1'b0;
      cyc(8);
      chk("off", {boost_en, sink_en, comp_float, shdn}, 7'h02);
      cyc(LONG_LOW);
      chk("shutdown", shdn, 1'b1);
    end
    level <= 1'b1;
    cyc(16);
    pwm_on <= 1'b1;
    repeat (3) begin
      @(posedge enable);
      cyc(10);
      chk("pwm high", sink_en, 4'hF);
      @(negedge enable);
      cyc(10);
      chk("pwm low", sink_en, 4'h0);
    end
    pwm_on <= 1'b0;
    cyc(16);
    overvoltage_sense <= 1'b1;
    ovp_rel <= 1'b0;
    cyc(8);
    overvoltage_sense <= 1'b0;
    cyc(8);
    apb(1'b0, `REG_STATUS, 32'h0, q, e);
    chk("ovp held", q[`ST_OVP], 1'b1);
    ovp_rel <= 1'b1;
    cyc(8);
    apb(1'b0, `REG_STATUS, 32'h0, q, e);
    chk("ovp free", q[`ST_OVP], 1'b0);
    m = 4'($urandom);
    m[0] = 1'b1;
    m[1] = 1'b0;
    ovp_pulse(m);
    chk("lockout", lockout, 4'(~m));
    ovp_pulse(~m);
    chk("relock", lockout, m);
    chk("locked sink", sink_en, 4'hF);
    level <= 1'b0;
    cyc(50);
    level <= 1'b1;
    cyc(8);
    chk("lock kept", lockout, m);
    // Run bit cleared over the bus holds boost and sinks off; only bit 0 is kept
    apb(1'b1, `REG_CTRL, 32'h0000_0000, q, e);
    apb(1'b0, `REG_CTRL, 32'h0000_0000, q, e);
    chk("ctrl write", q, 32'h0000_0000);
    cyc(4);
    chk("run off", {boost_en, sink_en}, 5'h00);
    apb(1'b1, `REG_CTRL, 32'hFFFF_FFFF, q, e);
    apb(1'b0, `REG_CTRL, 32'h0000_0000, q, e);
    chk("ctrl bits", q, `CTRL_RESET);
    cyc(8);
    chk("run on", {boost_en, sink_en}, 5'h1F);
    ilim <= 1'b1;
    cyc(8);
    chk("terminate", term, 1'b1);
    ilim <= 1'b0;
    cyc(8);
    chk("terminate", term, 1'b0);
    th_lo <= 1'b1;
    th_hi <= 1'b1;
    cyc(8);
    chk("thermal", th_follow, 1'b1);
    th_lo <= 1'b0;
    cyc(8);
    chk("thermal hys", th_follow, 1'b1);
    th_hi <= 1'b0;
    cyc(8);
    chk("thermal off", th_follow, 1'b0);
    // Supply faults: a short glitch is ignored, a long one stops the boost
    for (int k = 0; k < 2; k++) begin
      for (int n = 10; n <= FILT + 10; n += FILT) begin
        {ovlo, uv_low, uv_ok} <= k ? 3'h2 : 3'h5;
        cyc(n);
        {ovlo, uv_low, uv_ok} <= 3'h1;
        chk("supply", boost_en, n < FILT);
        cyc(16);
        chk("recover", boost_en, 1'b1);
      end
    end
    level <= 1'b0;
    cyc(SHORT_LOW);
    level <= 1'b1;
    cyc(20);
    level <= 1'b0;
    cyc(SHORT_LOW);
    chk("restart count", shdn, 1'b0);
    cyc(LONG_LOW);
    chk("clear", {shdn, lockout}, 5'h10);
    // Short on an unused channel, open diode, output overcurrent
    for (int f = 0; f < 3; f++) begin
      sel <= 2'h0;
      regulated <= 4'h1;
      level <= 1'b1;
      cyc(16);
      {oc, node_ov, shorted[3]} <= 3'h1 << f;
      cyc(8);
      chk("fault off", {boost_en, sink_en}, 5'h00);
      if (f == 2) begin
        chk("disconnect", disc_en, 1'b0);
      end
      {oc, node_ov, shorted[3]} <= 3'h0;
      level <= 1'b0;
      cyc(50);
      level <= 1'b1;
      cyc(8);
      chk("latched", boost_en, 1'b0);
      level <= 1'b0;
      cyc(LONG_LOW);
      level <= 1'b1;
      cyc(16);
      chk("cleared", boost_en, 1'b1);
    end
    conclude();
  end
endmodule : test_backlight_sequencer
